/* File: include/amd_consts.vh */
// constants for the address map decoder
`ifndef AMD_CONSTS_VH
`define AMD_CONSTS_VH
`define AMD_PHYS_MSB 25
`define AMD_PC_MASK 32'h03ff_ffff
`define AMD_PC_ALIGN 32'hffff_fffe
`define AMD_ROM_AREA_TOP 26'h00f_ffff
`define AMD_ROM_PHYS_TOP 26'h001_ffff
`define AMD_EXT_BASE 26'h010_0000
`define AMD_EXT_TOP 26'h07f_ffff
`define AMD_CS1_BASE 26'h020_0000
`define AMD_CS2_BASE 26'h040_0000
`define AMD_CS_WIN_MASK 26'h007_ffff
`define AMD_RAM_AREA_BASE 26'h3ff_0000
`define AMD_RAM_PHYS_BASE 26'h3ff_c800
`define AMD_RAM_PHYS_TOP 26'h3ff_efff
`define AMD_PIO_BASE 26'h3ff_f000
`define AMD_ROM_RESET_ENTRY 32'h0000_0000
`define AMD_EXT_RESET_ENTRY 32'h0000_0000
`define AMD_DL_ROMLESS 16'hffff
`define AMD_DH_ROMLESS 8'h07
`define AMD_CS_ROMLESS 8'h07
`define AMD_CT_ROMLESS 8'h13
`define AMD_CM_ROMLESS 8'h01
`define AMD_DL_SINGLE 16'h0000
`define AMD_B_SINGLE 8'h00
`define AMD_CM_KEEP_BIT 1
// region codes, one-hot
`define AMD_RG_NONE 6'h01
`define AMD_RG_ROM 6'h02
`define AMD_RG_RAM 6'h04
`define AMD_RG_PIO 6'h08
`define AMD_RG_EXT 6'h10
`define AMD_RG_ERR 6'h20
// access sizes
`define AMD_SZ_BYTE 2'h0
`define AMD_SZ_HALF 2'h1
`define AMD_SZ_WORD 2'h2
// apb map
`define AMD_APB_STATUS 12'h000
`define AMD_APB_PC 12'h004
`define AMD_APB_DL 12'h008
`define AMD_APB_DH 12'h00c
`define AMD_APB_CS 12'h010
`define AMD_APB_CT 12'h014
`define AMD_APB_CM 12'h018
`endif

/* File: verilog/amd_region_decode.v */
// combinational region decode of one 26-bit physical address
`timescale 1ns/1ps
`include "amd_consts.vh"
module amd_region_decode (
  input wire [25:0] phys,
  input wire is_fetch,
  input wire is_write,
  input wire romless,
  output reg [5:0] region,
  output reg [25:0] local_addr
);
  always @* begin
    region = `AMD_RG_NONE;
    local_addr = phys;
    if (phys >= `AMD_PIO_BASE) begin
      region = is_fetch ? `AMD_RG_ERR : `AMD_RG_PIO;
    end else if (phys >= `AMD_RAM_AREA_BASE) begin
      if (phys >= `AMD_RAM_PHYS_BASE && phys <= `AMD_RAM_PHYS_TOP) begin
        region = `AMD_RG_RAM;
      end
    end else if (phys <= `AMD_ROM_AREA_TOP) begin
      if (is_write && !is_fetch) begin
        region = `AMD_RG_EXT;
      end else if (romless) begin
        region = is_fetch ? `AMD_RG_EXT : `AMD_RG_ERR;
      end else if (phys <= `AMD_ROM_PHYS_TOP) begin
        region = `AMD_RG_ROM;
      end
    end else if (phys >= `AMD_EXT_BASE && phys <= `AMD_EXT_TOP) begin
      region = `AMD_RG_EXT;
      if (phys >= `AMD_CS2_BASE) begin
        local_addr = `AMD_CS2_BASE | (phys & `AMD_CS_WIN_MASK);
      end else if (phys >= `AMD_CS1_BASE) begin
        local_addr = `AMD_CS1_BASE | (phys & `AMD_CS_WIN_MASK);
      end else begin
        local_addr = `AMD_EXT_BASE | (phys & `AMD_CS_WIN_MASK);
      end
    end
  end
endmodule // amd_region_decode

/* File: verilog/amd_mode_latch.v */
// mode strap capture and mode-valid flag
`timescale 1ns/1ps
`include "amd_consts.vh"
module amd_mode_latch (
  input wire pclk,
  input wire presetn,
  input wire mode_strap,
  output reg romless_q,
  output reg mode_valid_q
);
  // strap is taken by a clocked process while reset is low and on the first clock after its release, then frozen
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_valid_q <= 1'b0;
    end else begin
      mode_valid_q <= 1'b1;
    end
  end
  always @(posedge pclk) begin
    if (!presetn || !mode_valid_q) begin
      romless_q <= ~mode_strap;
    end
  end
endmodule // amd_mode_latch

/* File: verilog/amd_addr_map.v */
// address map decoder top: mode, pc wrap, data decode, peripheral access split, apb view
// Behaviour
// - mode strap low selects romless with 16-bit external bus, high selects single-chip
// - single-chip: all bus pins are ports, boot from internal rom reset entry
// - romless: one pin stays port, rest bus control, boot from external memory
// - romless: no fetch or data access reaches internal rom
// - five pin function-select resets depend on mode
// - program counter keeps 26 bits, upper six zero, wraps
// - operand address arithmetic wraps at 32 bits
// - data address bits 31 to 26 ignored in decode
// - no instruction fetch from peripheral register area
// - lowest 1 MB is rom space, first 128 KB physical rom
// - only 3ffc800 to 3ffefff is physical ram, fetch allowed
// - top 4 KB routes to peripheral registers
// - word peripheral access is two halfword accesses, low first, addr[1:0] ignored
// - halfword to byte register: read upper byte undefined, write lower byte only
// - 0100000 to 07fffff routes to external memory
// - each chip-select region decodes 512 KB, rest aliases
// - lowest range: single-chip fetch and read to rom, data write to external
// - data address bit 25 sign-extends into upper bits
`timescale 1ns/1ps
`include "amd_consts.vh"
module amd_addr_map (
  input wire pclk,
  input wire presetn,
  input wire mode_strap,
  // program counter update from the core
  input wire pc_load,
  input wire [31:0] pc_target,
  input wire pc_step,
  input wire [31:0] pc_offset,
  output reg [31:0] program_counter_q,
  // instruction fetch decode
  output wire [5:0] fetch_region,
  output wire [25:0] fetch_local,
  // data access request
  input wire dreq_valid,
  input wire [31:0] dbase,
  input wire [31:0] ddisp,
  input wire dwrite,
  input wire [1:0] dsize,
  input wire [31:0] dwdata,
  input wire pio_byte_reg,
  output wire dreq_ready,
  output reg [31:0] dext_addr_q,
  output reg [5:0] dregion_q,
  output reg [25:0] dlocal_q,
  output reg drsp_valid_q,
  output reg [31:0] drdata_q,
  // peripheral halfword port
  output reg pio_valid_q,
  output reg pio_write_q,
  output reg [11:0] pio_addr_q,
  output reg [15:0] pio_wdata_q,
  input wire [15:0] pio_rdata,
  // pin function state
  output wire romless_mode,
  output wire retained_port_pin,
  output reg [15:0] low_data_pins_function_select_q,
  output reg [7:0] high_data_pins_function_select_q,
  output reg [7:0] chip_select_pins_function_select_q,
  output reg [7:0] control_pins_function_select_q,
  output reg [7:0] misc_pins_function_select_q,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr
);
  localparam ST_IDLE = 3'b001;
  localparam ST_LOW = 3'b010;
  localparam ST_HIGH = 3'b100;

  wire romless_q;
  wire mode_valid_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [15:0] low_half_q;
  // a word split is remembered here; the halfword address bit alone cannot tell a word from a halfword
  reg split_q;
  // upper write half kept at take so the core may drop dwdata after the request is accepted
  reg [15:0] hi_wdata_q;
  reg boot_done_q;
  wire [31:0] daddr;
  wire [25:0] dphys;
  wire [5:0] dregion;
  wire [25:0] dlocal;
  wire [31:0] pc_sum;
  wire apb_wr;
  wire apb_rd;

  amd_mode_latch u_mode (
    .pclk(pclk),
    .presetn(presetn),
    .mode_strap(mode_strap),
    .romless_q(romless_q),
    .mode_valid_q(mode_valid_q)
  );

  assign romless_mode = romless_q;
  // the retained pin is a general port in both modes, so it is never a bus function
  assign retained_port_pin = 1'b0;

  // pc: low 26 bits only, bit 0 forced low; carry out of bit 25 dropped
  assign pc_sum = program_counter_q + pc_offset;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      program_counter_q <= `AMD_ROM_RESET_ENTRY;
      boot_done_q <= 1'b0;
    end else if (!boot_done_q) begin
      boot_done_q <= mode_valid_q;
      program_counter_q <= romless_q ? `AMD_EXT_RESET_ENTRY : `AMD_ROM_RESET_ENTRY;
    end else if (pc_load) begin
      program_counter_q <= pc_target & `AMD_PC_MASK & `AMD_PC_ALIGN;
    end else if (pc_step) begin
      program_counter_q <= pc_sum & `AMD_PC_MASK & `AMD_PC_ALIGN;
    end
  end

  amd_region_decode u_fetch_dec (
    .phys(program_counter_q[25:0]),
    .is_fetch(1'b1),
    .is_write(1'b0),
    .romless(romless_q),
    .region(fetch_region),
    .local_addr(fetch_local)
  );

  // operand address: 32-bit sum, overflow dropped; decode uses low 26 bits only
  assign daddr = dbase + ddisp;
  assign dphys = daddr[`AMD_PHYS_MSB:0];

  amd_region_decode u_data_dec (
    .phys(dphys),
    .is_fetch(1'b0),
    .is_write(dwrite),
    .romless(romless_q),
    .region(dregion),
    .local_addr(dlocal)
  );

  // a new request is taken only when the peripheral splitter is idle
  assign dreq_ready = (state_q == ST_IDLE) && boot_done_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (dreq_valid && dreq_ready && dregion == `AMD_RG_PIO) begin
          state_d = (dsize == `AMD_SZ_WORD) ? ST_LOW : ST_HIGH;
        end
      end
      ST_LOW: begin
        state_d = ST_HIGH;
      end
      ST_HIGH: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ST_HIGH doubles as the single-phase state for byte and halfword accesses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      dext_addr_q <= 32'h0000_0000;
      dregion_q <= `AMD_RG_NONE;
      dlocal_q <= 26'h000_0000;
      drsp_valid_q <= 1'b0;
      drdata_q <= 32'h0000_0000;
      pio_valid_q <= 1'b0;
      pio_write_q <= 1'b0;
      pio_addr_q <= 12'h000;
      pio_wdata_q <= 16'h0000;
      low_half_q <= 16'h0000;
      split_q <= 1'b0;
      hi_wdata_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      drsp_valid_q <= 1'b0;
      pio_valid_q <= 1'b0;
      if (dreq_valid && dreq_ready) begin
        dext_addr_q <= {{6{dphys[`AMD_PHYS_MSB]}}, dphys};
        dregion_q <= dregion;
        dlocal_q <= dlocal;
        if (dregion == `AMD_RG_PIO) begin
          pio_valid_q <= 1'b1;
          pio_write_q <= dwrite;
          split_q <= (dsize == `AMD_SZ_WORD);
          hi_wdata_q <= dwdata[31:16];
          if (dsize == `AMD_SZ_WORD) begin
            pio_addr_q <= {dphys[11:2], 2'b00};
            pio_wdata_q <= dwdata[15:0];
          end else begin
            pio_addr_q <= dphys[11:0];
            // byte register written with a halfword keeps only the low byte
            pio_wdata_q <= pio_byte_reg ? {8'h00, dwdata[7:0]} : dwdata[15:0];
          end
        end else begin
          drsp_valid_q <= 1'b1;
          drdata_q <= 32'h0000_0000;
        end
      end else if (state_q == ST_LOW) begin
        low_half_q <= pio_rdata;
        pio_valid_q <= 1'b1;
        pio_addr_q <= {pio_addr_q[11:2], 2'b10};
        pio_wdata_q <= hi_wdata_q;
      end else if (state_q == ST_HIGH) begin
        drsp_valid_q <= 1'b1;
        if (split_q) begin
          drdata_q <= {pio_rdata, low_half_q};
        end else begin
          // upper byte of a byte register is undefined; it passes through unmasked
          drdata_q <= {16'h0000, pio_rdata};
        end
      end
    end
  end

  // pin function selects: reset value follows the latched mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_data_pins_function_select_q <= `AMD_DL_SINGLE;
      high_data_pins_function_select_q <= `AMD_B_SINGLE;
      chip_select_pins_function_select_q <= `AMD_B_SINGLE;
      control_pins_function_select_q <= `AMD_B_SINGLE;
      misc_pins_function_select_q <= `AMD_B_SINGLE;
    end else if (!boot_done_q) begin
      if (romless_q) begin
        low_data_pins_function_select_q <= `AMD_DL_ROMLESS;
        high_data_pins_function_select_q <= `AMD_DH_ROMLESS;
        chip_select_pins_function_select_q <= `AMD_CS_ROMLESS;
        control_pins_function_select_q <= `AMD_CT_ROMLESS;
        misc_pins_function_select_q <= `AMD_CM_ROMLESS;
      end else begin
        low_data_pins_function_select_q <= `AMD_DL_SINGLE;
        high_data_pins_function_select_q <= `AMD_B_SINGLE;
        chip_select_pins_function_select_q <= `AMD_B_SINGLE;
        control_pins_function_select_q <= `AMD_B_SINGLE;
        misc_pins_function_select_q <= `AMD_B_SINGLE;
      end
    end else if (apb_wr) begin
      case (paddr)
        `AMD_APB_DL: low_data_pins_function_select_q <= pwdata[15:0];
        `AMD_APB_DH: high_data_pins_function_select_q <= pwdata[7:0];
        `AMD_APB_CS: chip_select_pins_function_select_q <= pwdata[7:0];
        `AMD_APB_CT: control_pins_function_select_q <= pwdata[7:0];
        `AMD_APB_CM: misc_pins_function_select_q <= pwdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // apb slave: zero wait states
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign pslverr = psel && penable && (paddr > `AMD_APB_CM || paddr[1:0] != 2'b00 ||
                                       (pwrite && (paddr == `AMD_APB_STATUS || paddr == `AMD_APB_PC)));

  always @* begin
    prdata = 32'h0000_0000;
    if (apb_rd) begin
      case (paddr)
        `AMD_APB_STATUS: prdata = {29'h0000_0000, boot_done_q, state_q != ST_IDLE, romless_q};
        `AMD_APB_PC: prdata = program_counter_q;
        `AMD_APB_DL: prdata = {16'h0000, low_data_pins_function_select_q};
        `AMD_APB_DH: prdata = {24'h00_0000, high_data_pins_function_select_q};
        `AMD_APB_CS: prdata = {24'h00_0000, chip_select_pins_function_select_q};
        `AMD_APB_CT: prdata = {24'h00_0000, control_pins_function_select_q};
        `AMD_APB_CM: prdata = {24'h00_0000, misc_pins_function_select_q};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end
endmodule // amd_addr_map

/* File: testbench/amd_pio_model.sv */
// peripheral register side model answering the decoder's halfword port
`timescale 1ns/1ps
module amd_pio_model (
  input wire pclk,
  input wire presetn,
  input wire pio_valid_q,
  input wire [11:0] pio_addr_q,
  output wire [15:0] pio_rdata
);
  reg [11:0] a_q;
  reg hold_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      a_q <= 12'h000;
      hold_q <= 1'b0;
    end else begin
      hold_q <= pio_valid_q;
      if (pio_valid_q) a_q <= pio_addr_q;
    end
  end
  // data stands only through the strobe and the cycle after, then turns to garbage
  assign pio_rdata = pio_valid_q ? {4'ha, pio_addr_q} : (hold_q ? {4'ha, a_q} : ~{4'ha, a_q});
endmodule // amd_pio_model

/* File: testbench/amd_addr_map_monitor.sv */
// concurrent checks on the address map decoder ports
`timescale 1ns/1ps
`include "amd_consts.vh"
module amd_addr_map_monitor (
  input wire pclk,
  input wire presetn,
  input wire [31:0] program_counter_q,
  input wire [5:0] fetch_region,
  input wire dreq_valid,
  input wire [31:0] dbase,
  input wire [31:0] ddisp,
  input wire [1:0] dsize,
  input wire dreq_ready,
  input wire [31:0] dext_addr_q,
  input wire [5:0] dregion_q,
  input wire drsp_valid_q,
  input wire pio_valid_q,
  input wire [11:0] pio_addr_q,
  input wire romless_mode,
  input wire [15:0] low_data_pins_function_select_q,
  input wire [7:0] control_pins_function_select_q
);
  reg [31:0] a_q;
  wire take = dreq_valid && dreq_ready;
  wire [31:0] a = dbase + ddisp;
  wire pio = a[25:12] == 14'h3fff;
  always @(posedge pclk) begin
    if (take) a_q <= a;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence lo_half; pio_valid_q && pio_addr_q == {a_q[11:2], 2'h0}; endsequence
  sequence hi_half; pio_valid_q && pio_addr_q == {a_q[11:2], 2'h2}; endsequence
  AST_PC_UPPER: assert property (program_counter_q[31:26] == 6'h00 && !program_counter_q[0])
    else $error("pc upper bits set");
  AST_FETCH_PIO: assert property (program_counter_q[25:12] == 14'h3fff |-> fetch_region == `AMD_RG_ERR)
    else $error("fetch from peripheral area");
  AST_NO_ROM: assert property (romless_mode |-> fetch_region != `AMD_RG_ROM &&
    !(drsp_valid_q && dregion_q == `AMD_RG_ROM)) else $error("rom reached in romless");
  AST_EXT_SIGN: assert property (drsp_valid_q |-> dext_addr_q[31:26] == {6{dext_addr_q[25]}})
    else $error("address not sign extended");
  AST_PIO_WORD: assert property (take && pio && dsize == `AMD_SZ_WORD |=> lo_half ##1 hi_half ##1 drsp_valid_q)
    else $error("word split wrong");
  AST_PIO_HALF: assert property (take && pio && dsize != `AMD_SZ_WORD |=>
    pio_valid_q && pio_addr_q[11:1] == a_q[11:1] ##1 drsp_valid_q) else $error("peripheral access wrong");
  AST_EXT_ROUTE: assert property (drsp_valid_q && a_q[25:0] >= 26'h010_0000 && a_q[25:0] <= 26'h07f_ffff
    |-> dregion_q == `AMD_RG_EXT) else $error("external not routed");
  AST_RAM_ROUTE: assert property (drsp_valid_q && a_q[25:0] >= 26'h3ff_c800 && a_q[25:0] <= 26'h3ff_efff
    |-> dregion_q == `AMD_RG_RAM) else $error("ram not routed");
  AST_MODE_HOLD: assert property ($past(presetn, 3) |-> $stable(romless_mode))
    else $error("mode moved after reset");
  AST_SELECT_MODE: assert property ($past(presetn, 2) && !$past(presetn, 3) |->
    low_data_pins_function_select_q == (romless_mode ? 16'hffff : 16'h0000) &&
    control_pins_function_select_q == (romless_mode ? 8'h13 : 8'h00)) else $error("select reset wrong");
endmodule // amd_addr_map_monitor
bind amd_addr_map amd_addr_map_monitor mon (.pclk, .presetn, .program_counter_q, .fetch_region, .dreq_valid,
  .dbase, .ddisp, .dsize, .dreq_ready, .dext_addr_q, .dregion_q, .drsp_valid_q, .pio_valid_q, .pio_addr_q,
  .romless_mode, .low_data_pins_function_select_q, .control_pins_function_select_q);

/* File: testbench/amd_addr_map_tb.sv */
// self-checking bench for the address map decoder
`timescale 1ns/1ps
`include "amd_consts.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin bad_count++; $display("ERROR %0t got %h exp %h", $time, g, e); end end
module amd_addr_map_tb;
  reg pclk = 0, presetn = 0, mode_strap = 0, pc_load = 0, pc_step = 0;
  reg dreq_valid = 0, dwrite = 0, pio_byte_reg = 0, psel = 0, penable = 0, pwrite = 0;
  reg [31:0] pc_target = 0, pc_offset = 0, dbase = 0, ddisp = 0, dwdata = 0, pwdata = 0, rd, sv;
  reg [1:0] dsize = 0;
  reg [11:0] paddr = 0;
  reg err;
  wire [31:0] pc, dext, drdata, prdata;
  wire [5:0] freg, dreg;
  wire [25:0] floc, dloc;
  wire [15:0] dl, pio_rdata, pwd;
  wire [7:0] dh, cs, ct, cm;
  wire [11:0] pa;
  wire dready, drsp, pv, pw, romless, keep_pin, pready, pslverr;
  int bad_count = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  amd_addr_map uut (.pclk(pclk), .presetn(presetn), .mode_strap(mode_strap), .pc_load(pc_load),
    .pc_target(pc_target), .pc_step(pc_step), .pc_offset(pc_offset), .program_counter_q(pc),
    .fetch_region(freg), .fetch_local(floc), .dreq_valid(dreq_valid), .dbase(dbase), .ddisp(ddisp),
    .dwrite(dwrite), .dsize(dsize), .dwdata(dwdata), .pio_byte_reg(pio_byte_reg), .dreq_ready(dready),
    .dext_addr_q(dext), .dregion_q(dreg), .dlocal_q(dloc), .drsp_valid_q(drsp), .drdata_q(drdata),
    .pio_valid_q(pv), .pio_write_q(pw), .pio_addr_q(pa), .pio_wdata_q(pwd), .pio_rdata(pio_rdata),
    .romless_mode(romless), .retained_port_pin(keep_pin), .low_data_pins_function_select_q(dl),
    .high_data_pins_function_select_q(dh), .chip_select_pins_function_select_q(cs),
    .control_pins_function_select_q(ct), .misc_pins_function_select_q(cm), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  amd_pio_model pm (.pclk(pclk), .presetn(presetn), .pio_valid_q(pv), .pio_addr_q(pa), .pio_rdata(pio_rdata));
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset(input reg m);
    presetn <= 1'b0;
    mode_strap <= m;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic apb(input reg w, input reg [11:0] ad, input reg [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) bad_count++;
  endtask
  task automatic dacc(input reg [31:0] b, input reg [31:0] d, input reg w, input reg [1:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    dreq_valid <= 1'b1; dbase <= b; ddisp <= d; dwrite <= w; dsize <= s; dwdata <= 32'h1234_5678;
    do begin @(posedge pclk); n++; end while (dready !== 1'b1 && n < 20);
    dreq_valid <= 1'b0;
    do begin @(negedge pclk); n++; end while (drsp !== 1'b1 && n < 30);
    if (n >= 30) bad_count++;
  endtask
  task automatic pcl(input reg [31:0] t);
    @(posedge pclk);
    pc_load <= 1'b1; pc_target <= t;
    @(posedge pclk);
    pc_load <= 1'b0;
    @(negedge pclk);
  endtask
  initial begin
    do_reset(1'b0);
    mode_strap <= 1'b1;
    `CHK(romless, 1'b1)
    `CHK(keep_pin, 1'b0)
    `CHK({dl, dh, cs, ct, cm}, 48'hffff_0707_1301)
    apb(1'b0, `AMD_APB_CM, 32'h0);
    `CHK(rd[7:0], 8'h01)
    apb(1'b1, `AMD_APB_DL, 32'h0000_a5c3);
    apb(1'b0, `AMD_APB_DL, 32'h0);
    `CHK(rd[15:0], 16'ha5c3)
    apb(1'b1, `AMD_APB_PC, 32'h1);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h100, 32'h0);
    `CHK(err, 1'b1)
    pcl(32'hffff_fffb);
    @(posedge pclk); pc_step <= 1'b1; pc_offset <= 32'h0000_0008;
    @(posedge pclk); pc_step <= 1'b0;
    @(negedge pclk);
    `CHK(pc, 32'h0000_0002)
    pcl(32'h03ff_f010);
    `CHK(freg, `AMD_RG_ERR)
    pcl(32'h03ff_c800);
    `CHK(freg, `AMD_RG_RAM)
    pcl(32'h0);
    `CHK(freg, `AMD_RG_EXT)
    `CHK(romless, 1'b1)
    dacc(32'hffff_fff0, 32'h0000_0020, 1'b0, `AMD_SZ_WORD);
    `CHK(dext, 32'h0000_0010)
    `CHK(dreg, `AMD_RG_ERR)
    dacc(32'h0018_0010, 32'h0, 1'b0, `AMD_SZ_WORD);
    sv = {6'h00, dloc};
    dacc(32'h0010_0010, 32'h0, 1'b0, `AMD_SZ_WORD);
    `CHK({6'h00, dloc}, sv)
    `CHK(dloc, 26'h010_0010)
    `CHK(dreg, `AMD_RG_EXT)
    dacc(32'hfbff_c800, 32'h0, 1'b1, `AMD_SZ_WORD);
    `CHK(dreg, `AMD_RG_RAM)
    `CHK(dext, 32'hffff_c800)
    dacc(32'h03ff_c7fc, 32'h0, 1'b0, `AMD_SZ_WORD);
    `CHK(dreg, `AMD_RG_NONE)
    dacc(32'hffff_f100, 32'h7, 1'b0, `AMD_SZ_WORD);
    `CHK(dreg, `AMD_RG_PIO)
    `CHK(drdata, 32'ha106_a104)
    // peripheral stimulus stays on defined register offsets only
    pio_byte_reg <= 1'b1;
    dacc(32'hffff_f10a, 32'h0, 1'b0, `AMD_SZ_HALF);
    `CHK(drdata[7:0], 8'h0a)
    dacc(32'hffff_f110, 32'h0, 1'b1, `AMD_SZ_HALF);
    `CHK(pwd, 16'h0078)
    `CHK(pw, 1'b1)
    pio_byte_reg <= 1'b0;
    do_reset(1'b1);
    `CHK(romless, 1'b0)
    `CHK({dl, dh, cs, ct, cm}, 48'h0)
    `CHK(pc, `AMD_ROM_RESET_ENTRY)
    `CHK(freg, `AMD_RG_ROM)
    dacc(32'h10, 32'h0, 1'b0, `AMD_SZ_WORD);
    `CHK(dreg, `AMD_RG_ROM)
    dacc(32'h10, 32'h0, 1'b1, `AMD_SZ_WORD);
    `CHK(dreg, `AMD_RG_EXT)
    dacc(32'h0001_fffc, 32'h0, 1'b0, `AMD_SZ_WORD);
    `CHK(dreg, `AMD_RG_ROM)
    tally_and_finish;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    bad_count++;
    tally_and_finish;
  end
endmodule // amd_addr_map_tb
